// ### pkg/htc_pkg.sv
// Constants and types shared by the timer/counter design files.
// Assumes a single bus clock; all offsets are Avalon-MM byte addresses.
`default_nettype none

package htc_pkg;

  localparam int CNT_W = 16;
  localparam int ADR_W = 6;
  localparam int DAT_W = 32;
  localparam int PSC_W = 10;
  localparam int SEL_W = 3;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFF_CTRL     = 6'h00;
  localparam logic [ADR_W-1:0] OFF_TOP      = 6'h04;
  localparam logic [ADR_W-1:0] OFF_CMP      = 6'h08;
  localparam logic [ADR_W-1:0] OFF_RELOAD   = 6'h0c;
  localparam logic [ADR_W-1:0] OFF_COUNT    = 6'h10;
  localparam logic [ADR_W-1:0] OFF_CAPTURE  = 6'h14;
  localparam logic [ADR_W-1:0] OFF_IRQ_STAT = 6'h18;
  localparam logic [ADR_W-1:0] OFF_IRQ_EN   = 6'h1c;
  localparam logic [ADR_W-1:0] OFF_IRQ_SET  = 6'h20;

  // Control register fields
  localparam int CTRL_W        = 12;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DOWN     = 2;
  localparam int CTRL_EXT_CLK  = 3;
  localparam int CTRL_PSC_LSB  = 4;
  localparam int CTRL_CAP_EN   = 7;
  localparam int CTRL_AUTO_RLD = 8;
  localparam int CTRL_RUN      = 9;
  localparam int CTRL_BUS_IRQ  = 10;
  localparam int CTRL_RST_EN   = 11;

  // Preloaded values: run enabled, reset pin enabled, stand-alone irq
  localparam logic [CTRL_W-1:0] CTRL_RST   = 12'ha00;
  localparam logic [CNT_W-1:0]  TOP_RST    = 16'hffff;
  localparam logic [CNT_W-1:0]  CMP_RST    = 16'h8000;
  localparam logic [CNT_W-1:0]  RELOAD_RST = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_MAX    = 16'hffff;

  // Interrupt cause bits
  localparam int IRQ_W   = 3;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_CMP = 1;
  localparam int IRQ_CAP = 2;

  // Prescaler masks: divide by mask + 1
  localparam logic [PSC_W-1:0] PSC_MASK_1    = 10'h000;
  localparam logic [PSC_W-1:0] PSC_MASK_8    = 10'h007;
  localparam logic [PSC_W-1:0] PSC_MASK_64   = 10'h03f;
  localparam logic [PSC_W-1:0] PSC_MASK_256  = 10'h0ff;
  localparam logic [PSC_W-1:0] PSC_MASK_1024 = 10'h3ff;

  typedef enum logic [1:0] {
    HTC_WDT,
    HTC_CTC,
    HTC_FPWM,
    HTC_PFC
  } htc_mode_e;

endpackage

`default_nettype wire

// ### rtl/htc_prescale.sv
// Programmable prescaler: passes one of every N input ticks.
// Assumes i_tick is a one-cycle pulse in the i_mclk domain.
`default_nettype none

module htc_prescale (
  input  wire logic                      i_mclk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_clear,
  input  wire logic                      i_tick,
  input  wire logic [htc_pkg::SEL_W-1:0] i_sel,
  output var  logic                      o_tick
);
  import htc_pkg::*;

  logic [PSC_W-1:0] cnt_r;
  logic [PSC_W-1:0] mask;

  always_comb begin
    case (i_sel)
      3'h1:    mask = PSC_MASK_8;
      3'h2:    mask = PSC_MASK_64;
      3'h3:    mask = PSC_MASK_256;
      3'h4:    mask = PSC_MASK_1024;
      default: mask = PSC_MASK_1;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= '0;
    end else if (i_clear) begin
      cnt_r <= '0;
    end else if (i_tick) begin
      cnt_r <= cnt_r + 10'h001;
    end
  end

  // Masked compare never sticks when the divisor changes
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_tick & ~i_clear & ((cnt_r & mask) == mask);
    end
  end

endmodule

`default_nettype wire

// ### rtl/htc_sync.sv
// Two-stage synchroniser with a one-cycle rising edge pulse.
// Assumes the input is asynchronous to i_mclk.
`default_nettype none

module htc_sync (
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  input  wire logic i_d,
  output var  logic o_rise
);
  import htc_pkg::*;

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // One pulse per rising edge, seen after the second stage
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rise <= 1'b0;
    end else begin
      o_rise <= s2_r & ~s3_r;
    end
  end

endmodule

`default_nettype wire

// ### rtl/htc_top.sv
// 16-bit up/down timer/counter with compare, PWM and input capture.
// Assumes an Avalon-MM master on i_mclk; timer pins sampled on i_mclk.
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`default_nettype none

module htc_top (
  input  wire logic                      i_mclk,
  input  wire logic                      i_arst_n,
  input  wire logic [htc_pkg::ADR_W-1:0] i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [htc_pkg::DAT_W-1:0] i_avs_writedata,
  input  wire logic [3:0]                i_avs_byteenable,
  output var  logic [htc_pkg::DAT_W-1:0] o_avs_readdata,
  output var  logic                      o_avs_waitrequest,
  input  wire logic                      i_timer_clock_in,
  input  wire logic                      i_timer_reset_n,
  input  wire logic                      i_capture_trigger_in,
  output var  logic                      o_waveform_out,
  output var  logic                      o_timer_irq_out,
  output var  logic                      o_wake_irq_out
);
  import htc_pkg::*;

  logic [CTRL_W-1:0] ctrl_r;
  logic [CNT_W-1:0]  top_r;
  logic [CNT_W-1:0]  cmp_r;
  logic [CNT_W-1:0]  reload_r;
  logic [CNT_W-1:0]  count_value_r;
  logic [CNT_W-1:0]  capture_value_reg_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_en_r;
  logic [CNT_W-1:0]  top_act_r;
  logic [CNT_W-1:0]  cmp_act_r;
  logic              dir_down_r;

  logic [CNT_W-1:0]  cnt_nxt;
  logic              dir_nxt;
  logic              wave_nxt;
  logic              ovf_ev;
  logic              cmp_ev;
  logic              cap_ev;
  logic              buf_load;
  logic [CNT_W-1:0]  cmp_use;
  logic [IRQ_W-1:0]  ev_vec;
  logic [DAT_W-1:0]  rd_nxt;
  logic [DAT_W-1:0]  wmask;
  logic [DAT_W-1:0]  wdat;
  logic              wr_go;
  logic              clk_rise;
  logic              cap_rise;
  logic              src_tick;
  logic              tick;
  logic              tmr_rst;
  logic              bus_mode;
  logic              pwm_mode;
  htc_mode_e         mode;

  assign mode     = htc_mode_e'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign pwm_mode = (mode == HTC_FPWM) || (mode == HTC_PFC);
  assign bus_mode = ctrl_r[CTRL_BUS_IRQ];
  assign tmr_rst  = ctrl_r[CTRL_RST_EN] & ~i_timer_reset_n;

  // Timer clock pin edges drive the counter
  htc_sync u_clk_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_d      (i_timer_clock_in),
    .o_rise   (clk_rise)
  );

  htc_sync u_cap_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_d      (i_capture_trigger_in),
    .o_rise   (cap_rise)
  );

  // Source select then prescaler
  assign src_tick = ctrl_r[CTRL_EXT_CLK] ? clk_rise : 1'b1;

  htc_prescale u_psc (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_clear  (~ctrl_r[CTRL_RUN] | tmr_rst),
    .i_tick   (src_tick),
    .i_sel    (ctrl_r[CTRL_PSC_LSB +: SEL_W]),
    .o_tick   (tick)
  );

  // Bus write strobe with byte lanes
  assign wr_go = i_avs_write & ~o_avs_waitrequest;
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
  end
  assign wdat = i_avs_writedata & wmask;

  function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
                                               input logic [DAT_W-1:0] d,
                                               input logic [DAT_W-1:0] m);
    merge16 = (old & ~m[CNT_W-1:0]) | d[CNT_W-1:0];
  endfunction

  // Counter next state per mode
  always_comb begin
    cnt_nxt  = count_value_r;
    // Direction held between prescaled ticks in PFC mode, cleared in the other modes
    dir_nxt  = (mode == HTC_PFC) ? dir_down_r : 1'b0;
    ovf_ev   = 1'b0;
    cmp_ev   = 1'b0;
    buf_load = 1'b0;
    if (tick) begin
      cmp_ev = (count_value_r == cmp_act_r);
      case (mode)
        HTC_WDT, HTC_CTC: begin
          if (ctrl_r[CTRL_DOWN]) begin
            if (count_value_r == '0) begin
              ovf_ev  = 1'b1;
              cnt_nxt = ctrl_r[CTRL_AUTO_RLD] ? reload_r : CNT_MAX;
            end else begin
              cnt_nxt = count_value_r - 16'h0001;
            end
          end else if (mode == HTC_CTC && cmp_ev) begin
            cnt_nxt = ctrl_r[CTRL_AUTO_RLD] ? reload_r : '0;
          end else if (count_value_r == CNT_MAX) begin
            ovf_ev  = 1'b1;
            cnt_nxt = ctrl_r[CTRL_AUTO_RLD] ? reload_r : '0;
          end else begin
            cnt_nxt = count_value_r + 16'h0001;
          end
        end
        HTC_FPWM: begin
          if (count_value_r >= top_act_r) begin
            ovf_ev   = 1'b1;
            buf_load = 1'b1;
            cnt_nxt  = '0;
          end else begin
            cnt_nxt = count_value_r + 16'h0001;
          end
        end
        HTC_PFC: begin
          dir_nxt = dir_down_r;
          if (!dir_down_r) begin
            if (count_value_r >= top_act_r) begin
              dir_nxt = 1'b1;
              cnt_nxt = (count_value_r == '0) ? '0
                                              : count_value_r - 16'h0001;
            end else begin
              cnt_nxt = count_value_r + 16'h0001;
            end
          end else if (count_value_r == '0) begin
            dir_nxt  = 1'b0;
            ovf_ev   = 1'b1;
            buf_load = 1'b1;
            cnt_nxt  = (top_act_r == '0) ? '0 : 16'h0001;
          end else begin
            cnt_nxt = count_value_r - 16'h0001;
          end
        end
        default: cnt_nxt = count_value_r;
      endcase
    end
  end

  // Waveform only moves on a tick, from buffered compare
  assign cmp_use = buf_load ? cmp_r : cmp_act_r;
  always_comb begin
    wave_nxt = o_waveform_out;
    if (tick) begin
      if (pwm_mode) begin
        wave_nxt = (cnt_nxt < cmp_use);
      end else if (cmp_ev) begin
        wave_nxt = ~o_waveform_out;
      end
    end
  end

  // Capture only in non-PWM bus mode
  assign cap_ev = cap_rise & ctrl_r[CTRL_CAP_EN] & bus_mode & ~pwm_mode;
  assign ev_vec = {cap_ev, cmp_ev, ovf_ev};

  // Configuration registers, reset to preloaded values
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r   <= CTRL_RST;
      top_r    <= TOP_RST;
      cmp_r    <= CMP_RST;
      reload_r <= RELOAD_RST;
      irq_en_r <= '0;
    end else if (wr_go) begin
      case (i_avs_address)
        OFF_CTRL:   ctrl_r   <= (ctrl_r & ~wmask[CTRL_W-1:0])
                                | wdat[CTRL_W-1:0];
        OFF_TOP:    top_r    <= merge16(top_r, wdat, wmask);
        OFF_CMP:    cmp_r    <= merge16(cmp_r, wdat, wmask);
        OFF_RELOAD: reload_r <= merge16(reload_r, wdat, wmask);
        OFF_IRQ_EN: irq_en_r <= (irq_en_r & ~wmask[IRQ_W-1:0])
                                | wdat[IRQ_W-1:0];
        default:    ctrl_r   <= ctrl_r;
      endcase
    end
  end

  // Counter, direction and shadow buffers
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_value_r <= '0;
      dir_down_r    <= 1'b0;
      top_act_r     <= TOP_RST;
      cmp_act_r     <= CMP_RST;
    end else if (tmr_rst) begin
      count_value_r <= '0;
      dir_down_r    <= 1'b0;
      top_act_r     <= top_r;
      cmp_act_r     <= cmp_r;
    end else begin
      if (wr_go && i_avs_address == OFF_COUNT) begin
        count_value_r <= merge16(count_value_r, wdat, wmask);
      end else if (ctrl_r[CTRL_RUN]) begin
        count_value_r <= cnt_nxt;
      end
      dir_down_r <= dir_nxt;
      if (!pwm_mode || buf_load) begin
        top_act_r <= top_r;
        cmp_act_r <= cmp_r;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_waveform_out <= 1'b0;
    end else if (tmr_rst) begin
      o_waveform_out <= 1'b0;
    end else if (ctrl_r[CTRL_RUN]) begin
      o_waveform_out <= wave_nxt;
    end
  end

  // Time stamp on capture
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      capture_value_reg_r <= '0;
    end else if (tmr_rst) begin
      capture_value_reg_r <= '0;
    end else if (cap_ev) begin
      capture_value_reg_r <= count_value_r;
    end
  end

  // Sticky causes: hardware set wins over write-1-clear
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_r <= '0;
    end else if (tmr_rst) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r
                     & ~((wr_go && i_avs_address == OFF_IRQ_STAT)
                         ? wdat[IRQ_W-1:0] : 3'h0))
                    | ((wr_go && i_avs_address == OFF_IRQ_SET)
                       ? wdat[IRQ_W-1:0] : 3'h0)
                    | (ctrl_r[CTRL_RUN] ? ev_vec : 3'h0);
    end
  end

  // Static and wake-up interrupt pins
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_timer_irq_out <= 1'b0;
      o_wake_irq_out  <= 1'b0;
    end else if (bus_mode) begin
      o_timer_irq_out <= |(irq_stat_r & irq_en_r);
      o_wake_irq_out  <= ctrl_r[CTRL_RUN] & |(ev_vec & irq_en_r);
    end else begin
      o_timer_irq_out <= irq_stat_r[IRQ_OVF];
      o_wake_irq_out  <= ctrl_r[CTRL_RUN] & ovf_ev;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_nxt = '0;
    case (i_avs_address)
      OFF_CTRL:     rd_nxt[CTRL_W-1:0] = ctrl_r;
      OFF_TOP:      rd_nxt[CNT_W-1:0]  = top_r;
      OFF_CMP:      rd_nxt[CNT_W-1:0]  = cmp_r;
      OFF_RELOAD:   rd_nxt[CNT_W-1:0]  = reload_r;
      OFF_COUNT:    rd_nxt[CNT_W-1:0]  = count_value_r;
      OFF_CAPTURE:  rd_nxt[CNT_W-1:0]  = capture_value_reg_r;
      OFF_IRQ_STAT: rd_nxt[IRQ_W-1:0]  = irq_stat_r;
      OFF_IRQ_EN:   rd_nxt[IRQ_W-1:0]  = irq_en_r;
      default:      rd_nxt             = '0;
    endcase
  end

  // One wait cycle per access, data captured while waiting
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= '0;
    end else begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write)
                             & o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        o_avs_readdata <= rd_nxt;
      end
    end
  end

endmodule

`default_nettype wire

// ### verification/htc_asserts.sv
// Port-level checks for the timer/counter top module.
// Assumes it is bound into htc_top; one clock, async active-low reset.
`default_nettype none

module htc_asserts (
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  input wire logic [5:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_timer_clock_in,
  input wire logic        i_timer_reset_n,
  input wire logic        i_capture_trigger_in,
  input wire logic        o_waveform_out,
  input wire logic        o_timer_irq_out,
  input wire logic        o_wake_irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import htc_pkg::*;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_rd;
    i_avs_read && o_avs_waitrequest;
  endsequence
  sequence s_pin_low;
    !i_timer_reset_n ##1 !i_timer_reset_n;
  endsequence

  wait_answer_a: assert property (s_req |=> !o_avs_waitrequest)
    else $error("request not answered");
  wait_pulse_a: assert property (
    $fell(o_avs_waitrequest) |=> $rose(o_avs_waitrequest))
    else $error("answer longer than one cycle");
  rd_hold_a: assert property (
    !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data changed");
  unmapped_zero_a: assert property (s_rd ##0
    (i_avs_address[1:0] != 2'h0 || i_avs_address >= OFF_IRQ_SET)
    |=> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
  upper_zero_a: assert property (s_rd ##0
    (i_avs_address <= OFF_CAPTURE) |=> o_avs_readdata[31:16] == 16'h0)
    else $error("count read wider than 16 bits");
  pin_wave_a: assert property (s_pin_low |-> !o_waveform_out)
    else $error("waveform kept in timer reset");
  pin_irq_a: assert property (s_pin_low |=> !o_timer_irq_out)
    else $error("irq kept in timer reset");
  // Wake pulse marks a latched cause, so the static pin follows
  wake_irq_a: assert property (o_wake_irq_out
    && $past(i_timer_reset_n) && !$past(i_avs_write) |=> o_timer_irq_out)
    else $error("wake pulse without irq");
endmodule

bind htc_top htc_asserts u_chk (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_timer_clock_in(i_timer_clock_in), .i_timer_reset_n(i_timer_reset_n),
  .i_capture_trigger_in(i_capture_trigger_in),
  .o_waveform_out(o_waveform_out), .o_timer_irq_out(o_timer_irq_out),
  .o_wake_irq_out(o_wake_irq_out));

`default_nettype wire

// ### verification/htc_avm.sv
// Fabric-side bus master model with word read and write tasks.
// Assumes the slave answers by dropping waitrequest for one cycle.
`default_nettype none

module htc_avm (
  input  wire logic        i_mclk,
  input  wire logic        i_waitrequest,
  input  wire logic [31:0] i_readdata,
  output var  logic [5:0]  o_address,
  output var  logic        o_read,
  output var  logic        o_write,
  output var  logic [31:0] o_writedata,
  output var  logic [3:0]  o_byteenable
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_address = 6'h3f;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
    o_byteenable = 4'hf;
  end

  // Released lines show the inverse of the last value
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    o_address <= a;
    o_writedata <= d;
    o_write <= 1'b1;
    do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
    o_write <= 1'b0;
    o_address <= ~a;
    o_writedata <= ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    o_address <= a;
    o_read <= 1'b1;
    do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
    d = i_readdata;
    o_read <= 1'b0;
    o_address <= ~a;
  endtask
endmodule

`default_nettype wire

// ### verification/htc_top_test.sv
// Self-checking bench for the timer/counter top level.
// Assumes htc_avm as bus master and htc_asserts bound to the design.
`default_nettype none

module htc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import htc_pkg::*;

  logic        i_mclk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        i_timer_clock_in = 1'b0;
  logic        i_timer_reset_n = 1'b1;
  logic        i_capture_trigger_in = 1'b0;
  logic [5:0]  adr;
  logic        a_rd;
  logic        a_wr;
  logic [31:0] wdat;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wreq;
  logic        wave;
  logic        irq;
  logic        wake;
  logic [1:0]  div = 2'h0;
  logic [31:0] v;
  logic [31:0] v2;
  logic [31:0] c;
  logic [31:0] h;
  int          errors = 0;
  int          comparisons = 0;
  int          wakes = 0;
  int          w0;
  logic [5:0]  radr [8] = '{OFF_CTRL, OFF_TOP, OFF_CMP, OFF_RELOAD,
    OFF_CAPTURE, OFF_IRQ_STAT, OFF_IRQ_EN, 6'h24};
  logic [31:0] rexp [8] = '{32'(CTRL_RST), 32'(TOP_RST), 32'(CMP_RST),
    32'(RELOAD_RST), 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] pre [2] = '{32'ha10, 32'ha08};
  logic [31:0] pexp [2] = '{32'ha, 32'h14};
  // Control, top, compare, window, expected high cycles
  logic [31:0] mrow [3][5] = '{'{32'ha02, 32'hf, 32'h4, 32'h40, 32'h10},
    '{32'ha01, 32'hf, 32'h9, 32'h50, 32'h28},
    '{32'ha03, 32'hf, 32'h4, 32'h5a, 32'h15}};

  htc_avm u_avm (.i_mclk(i_mclk), .i_waitrequest(wreq), .i_readdata(rdat),
    .o_address(adr), .o_read(a_rd), .o_write(a_wr), .o_writedata(wdat),
    .o_byteenable(be));

  htc_top uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_avs_address(adr),
    .i_avs_read(a_rd), .i_avs_write(a_wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_timer_clock_in(i_timer_clock_in), .i_timer_reset_n(i_timer_reset_n),
    .i_capture_trigger_in(i_capture_trigger_in), .o_waveform_out(wave),
    .o_timer_irq_out(irq), .o_wake_irq_out(wake));

  always #25 i_mclk = ~i_mclk;

  // Timer pin runs at a quarter of the bus clock
  always @(posedge i_mclk) begin
    div <= div + 2'h1;
    i_timer_clock_in <= div[1];
    if (wake === 1'b1) wakes <= wakes + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic meas(input logic [31:0] n, output logic [31:0] hi);
    hi = 32'h0;
    repeat (n) begin
      @(posedge i_mclk);
      if (wave === 1'b1) hi = hi + 32'h1;
    end
  endtask

  task automatic pin_pulse;
    @(posedge i_mclk);
    i_timer_reset_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_timer_reset_n <= 1'b1;
  endtask

  task close_out;
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    foreach (radr[k]) begin
      u_avm.rd(radr[k], v);
      chk(v, rexp[k]);
    end
    u_avm.wr(OFF_CAPTURE, 32'h1234);
    u_avm.rd(OFF_CAPTURE, v);
    chk(v, 32'h0);
    u_avm.wr(OFF_COUNT, 32'hfff0);
    u_avm.rd(OFF_COUNT, v);
    chk(v, 32'hfff1);
    u_avm.rd(OFF_COUNT, v);
    chk(v, 32'hfff4);
    repeat (20) @(posedge i_mclk);
    chk({31'h0, irq}, 32'h1);
    u_avm.wr(OFF_RELOAD, 32'h100);
    u_avm.wr(OFF_CTRL, 32'hb00);
    u_avm.wr(OFF_COUNT, 32'hfffe);
    u_avm.rd(OFF_COUNT, v);
    u_avm.rd(OFF_COUNT, v);
    chk(v, 32'h102);
    pin_pulse();
    @(posedge i_mclk);
    chk({31'h0, irq}, 32'h0);
    u_avm.wr(OFF_CTRL, 32'ha04);
    u_avm.wr(OFF_COUNT, 32'h50);
    u_avm.rd(OFF_COUNT, v);
    u_avm.rd(OFF_COUNT, v2);
    chk(v - v2, 32'h3);
    foreach (pre[k]) begin
      u_avm.wr(OFF_CTRL, pre[k]);
      u_avm.rd(OFF_COUNT, v);
      repeat (77) @(posedge i_mclk);
      u_avm.rd(OFF_COUNT, v2);
      chk(v2 - v, pexp[k]);
    end
    foreach (mrow[k]) begin
      u_avm.wr(OFF_TOP, mrow[k][1]);
      u_avm.wr(OFF_CMP, mrow[k][2]);
      u_avm.wr(OFF_CTRL, mrow[k][0]);
      pin_pulse();
      repeat (40) @(posedge i_mclk);
      meas(mrow[k][3], h);
      chk(h, mrow[k][4]);
    end
    u_avm.wr(OFF_CTRL, 32'he80);
    u_avm.wr(OFF_IRQ_EN, 32'h4);
    w0 = wakes;
    u_avm.rd(OFF_COUNT, c);
    i_capture_trigger_in <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_capture_trigger_in <= 1'b0;
    repeat (10) @(posedge i_mclk);
    u_avm.rd(OFF_CAPTURE, v);
    chk(v - c, 32'h5);
    u_avm.rd(OFF_IRQ_STAT, v);
    chk(v & 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h1);
    chk(32'(wakes > w0), 32'h1);
    u_avm.wr(OFF_IRQ_STAT, 32'h7);
    u_avm.wr(OFF_IRQ_SET, 32'h2);
    repeat (2) @(posedge i_mclk);
    chk({31'h0, irq}, 32'h0);
    u_avm.rd(OFF_IRQ_STAT, v);
    chk(v, 32'h2);
    u_avm.wr(OFF_IRQ_EN, 32'h6);
    repeat (2) @(posedge i_mclk);
    chk({31'h0, irq}, 32'h1);
    close_out();
  end

  initial begin
    repeat (5000) @(posedge i_mclk);
    errors++;
    close_out();
  end
endmodule

`default_nettype wire
